// ==== src/tpu_timer.sv ====
// Prescaler, clock selection and 16-bit up or up/down counter of one timer channel.
// Assumes clk is the base clock, a register master on the same clock, and
// asynchronous external clock and phase pins.
//
// Overview of operation
// - Five-bit prescaler divides the selected source
// - Source is peripheral clock over 16, 8, 4
// - Peripheral clock is geared or base clock
// - Run one starts prescaler, zero clears it
// - Sixteen-bit counter clocked by selected source
// - Select three taps or the external pin
// - Run starts counter, stop clears it
// - Clear to zero on reaching the period
// - Mode bit enables clear on match
// - Without clear, counter runs free and wraps
// - Overflow past maximum without a period-match clear raises overflow interrupt
// - Two-phase enable gives up/down, preloads 7fff
// - Two-phase overflow loads zero
// - Two-phase underflow loads ffff
// - Outside two-phase, counting is upward only
// - Match flagged while counter equals period
// - Two-phase bit zero normal, one up/down
`default_nettype none

module tpu_timer #(
	parameter int PRE_W = 5,
	parameter int CNT_W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic ext_clock_in,
	input wire logic phase_b_in,
	output logic overflow_irq,
	output logic match_out,
	output logic [15:0] count_out
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// Taps need four prescaler bits; the register map is fixed at 16 bits
	if (PRE_W < 5) begin : g_pre_chk
		$error("PRE_W must be at least 5");
	end
	if (CNT_W != 16) begin : g_cnt_chk
		$error("CNT_W must be 16");
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [15:0] ctrl_r;
	logic [15:0] mode_r;
	logic [15:0] period_r;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic ovf_r;
	logic ovf_nxt;
	logic match_r;
	logic [2:0] gear_r;
	logic [3:0] src_div_r;
	logic [PRE_W-1:0] pre_r;
	logic ext_s1_r;
	logic ext_s2_r;
	logic ext_d_r;
	logic phb_s1_r;
	logic phb_s2_r;
	logic phb_d_r;
	logic tp_arm_r;

	// ----------------------------------------
	// Register decode
	// ----------------------------------------
	wire wr_ctrl = reg_wr && (reg_addr == tpu_pkg::OFF_CTRL);
	wire wr_mode = reg_wr && (reg_addr == tpu_pkg::OFF_MODE);
	wire wr_period = reg_wr && (reg_addr == tpu_pkg::OFF_PERIOD);
	wire run = ctrl_r[tpu_pkg::CTRL_RUN_BIT];
	wire pclk_sel = ctrl_r[tpu_pkg::CTRL_PCLK_BIT];
	wire [1:0] psrc_sel = ctrl_r[tpu_pkg::CTRL_PSRC_LSB +: 2];
	wire [1:0] gear_sel = ctrl_r[tpu_pkg::CTRL_GEAR_LSB +: 2];
	wire tp_en = ctrl_r[tpu_pkg::CTRL_TPEN_BIT];
	wire [1:0] csel = mode_r[tpu_pkg::MODE_CSEL_LSB +: 2];
	wire mce = mode_r[tpu_pkg::MODE_MCE_BIT];

	// Software registers; unused bits are not stored and read back as zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_r <= tpu_pkg::CTRL_RST;
			mode_r <= tpu_pkg::MODE_RST;
			period_r <= tpu_pkg::PERIOD_RST;
		end else begin
			if (wr_ctrl) ctrl_r <= {9'h000, reg_wdata[6:0]};
			if (wr_mode) mode_r <= {13'h0000, reg_wdata[2:0]};
			if (wr_period) period_r <= reg_wdata;
		end
	end

	// ----------------------------------------
	// Clock gearing and peripheral clock
	// ----------------------------------------
	// Gear divides the base clock by 1, 2, 4 or 8 as a free-running tick
	wire gear_tick = (gear_sel == 2'h0) ? 1'b1 :
		(gear_sel == 2'h1) ? (gear_r[0] == 1'b1) :
		(gear_sel == 2'h2) ? (gear_r[1:0] == 2'h3) : (gear_r == 3'h7);
	// Geared clock when select is 0, base clock when 1
	wire periph_tick = pclk_sel ? 1'b1 : gear_tick;

	always_ff @(posedge clk) begin
		if (!rst_n) gear_r <= 3'h0;
		else gear_r <= gear_r + 3'h1;
	end

	// ----------------------------------------
	// Prescaler source divider
	// ----------------------------------------
	// Code 11 is undefined; it falls back to the slowest ratio
	wire src_tick = periph_tick && ((psrc_sel == tpu_pkg::PSRC_DIV4) ? (src_div_r[1:0] == 2'h3) :
		(psrc_sel == tpu_pkg::PSRC_DIV8) ? (src_div_r[2:0] == 3'h7) : (src_div_r == 4'hf));

	// Cleared with the prescaler so the first tap edge after start is a full period
	always_ff @(posedge clk) begin
		if (!rst_n) src_div_r <= 4'h0;
		else if (!run) src_div_r <= 4'h0;
		else if (periph_tick) src_div_r <= src_div_r + 4'h1;
	end

	// ----------------------------------------
	// Five-bit prescaler and taps
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) pre_r <= '0;
		else if (!run) pre_r <= '0;
		else if (src_tick) pre_r <= pre_r + PRE_W'(1);
	end

	// Taps at 1, 4 and 16 input periods, taken as carries out of the low bits
	wire tap_div1 = src_tick;
	wire tap_div4 = src_tick && (pre_r[1:0] == 2'h3);
	wire tap_div16 = src_tick && (pre_r[3:0] == 4'hf);

	// Assertion helper: fast-tap strobes counted modulo 16 since start, an
	// independent reference for the slower taps rather than a copy of their decode
	logic [3:0] t1_cnt_r;
	always_ff @(posedge clk) begin
		if (!rst_n) t1_cnt_r <= 4'h0;
		else if (!run) t1_cnt_r <= 4'h0;
		else if (tap_div1) t1_cnt_r <= t1_cnt_r + 4'h1;
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Two flops against metastability, a third only for edge detection
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_d_r <= 1'b0;
			phb_s1_r <= 1'b0;
			phb_s2_r <= 1'b0;
			phb_d_r <= 1'b0;
		end else begin
			ext_s1_r <= ext_clock_in;
			ext_s2_r <= ext_s1_r;
			ext_d_r <= ext_s2_r;
			phb_s1_r <= phase_b_in;
			phb_s2_r <= phb_s1_r;
			phb_d_r <= phb_s2_r;
		end
	end

	// One count per external rising edge; pulses must be wider than two clocks
	wire ext_rise = ext_s2_r && !ext_d_r;

	// ----------------------------------------
	// Count clock selection
	// ----------------------------------------
	wire sel_tick = (csel == tpu_pkg::CSEL_EXT) ? ext_rise :
		(csel == tpu_pkg::CSEL_TAP1) ? tap_div1 :
		(csel == tpu_pkg::CSEL_TAP4) ? tap_div4 : tap_div16;
	wire cnt_tick = run && !tp_en && sel_tick;

	// ----------------------------------------
	// Two-phase decoding
	// ----------------------------------------
	// Phase A shares the external clock pin; A leading B counts up.
	// A step where both phases move at once is ambiguous and is dropped.
	wire a_chg = ext_s2_r ^ ext_d_r;
	wire b_chg = phb_s2_r ^ phb_d_r;
	wire one_chg = a_chg ^ b_chg;
	wire qd_up = run && tp_en && one_chg && (ext_s2_r ^ phb_d_r);
	wire qd_dn = run && tp_en && one_chg && !(ext_s2_r ^ phb_d_r);
	// Preload once as two-phase counting becomes active
	wire tp_load = run && tp_en && !tp_arm_r;

	always_ff @(posedge clk) begin
		if (!rst_n) tp_arm_r <= 1'b0;
		else tp_arm_r <= run && tp_en;
	end

	// ----------------------------------------
	// Counter next state
	// ----------------------------------------
	// Stop-and-clear beats everything; preload beats a coincident phase step
	always_comb begin
		cnt_nxt = cnt_r;
		ovf_nxt = 1'b0;
		if (!run) begin
			cnt_nxt = tpu_pkg::CNT_CLEAR;
		end else if (tp_load) begin
			cnt_nxt = tpu_pkg::TP_PRELOAD;
		end else if (qd_up) begin
			if (cnt_r == tpu_pkg::CNT_MAX) begin
				cnt_nxt = tpu_pkg::TP_OVF_LOAD;
				ovf_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 16'h0001;
			end
		end else if (qd_dn) begin
			if (cnt_r == tpu_pkg::CNT_CLEAR) cnt_nxt = tpu_pkg::TP_UDF_LOAD;
			else cnt_nxt = cnt_r - 16'h0001;
		end else if (cnt_tick) begin
			if (mce && (cnt_r == period_r)) begin
				cnt_nxt = tpu_pkg::CNT_CLEAR;
			end else if (cnt_r == tpu_pkg::CNT_MAX) begin
				cnt_nxt = tpu_pkg::CNT_CLEAR;
				ovf_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 16'h0001;
			end
		end
	end

	// Counter, overflow pulse and match level
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r <= tpu_pkg::CNT_CLEAR;
			ovf_r <= 1'b0;
			match_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			ovf_r <= ovf_nxt;
			match_r <= (cnt_nxt == period_r);
		end
	end

	// ----------------------------------------
	// Register read
	// ----------------------------------------
	// Data stand for exactly one cycle after the strobe; unmapped reads give zero
	wire [15:0] stat_word = {13'h0000, tp_en, run, match_r};
	always_comb begin
		rdata_nxt = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				tpu_pkg::OFF_CTRL: rdata_nxt = ctrl_r;
				tpu_pkg::OFF_MODE: rdata_nxt = mode_r;
				tpu_pkg::OFF_PERIOD: rdata_nxt = period_r;
				tpu_pkg::OFF_COUNT: rdata_nxt = cnt_r;
				tpu_pkg::OFF_STATUS: rdata_nxt = stat_word;
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) rdata_r <= 16'h0000;
		else rdata_r <= rdata_nxt;
	end

	assign reg_rdata = rdata_r;
	assign overflow_irq = ovf_r;
	assign match_out = match_r;
	assign count_out = cnt_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_stop;
		!run;
	endsequence
	sequence s_cleared;
		(cnt_r == tpu_pkg::CNT_CLEAR) && (pre_r == '0);
	endsequence
	sequence s_tp_active;
		run && tp_en && tp_arm_r;
	endsequence

	a_stop_clears: assert property (s_stop |=> s_cleared)
		else $error("Stopped timer not cleared");
	// Checked by value: the cycle after a stop may still show the last running count
	a_pre_idle: assert property (!run && $past(!run) |-> pre_r == '0)
		else $error("Prescaler moved while halted");
	a_match_clear: assert property (cnt_tick && mce && cnt_r == period_r |=> cnt_r == 16'h0000)
		else $error("Counter not cleared on match");
	a_free_wrap: assert property (cnt_tick && !mce && cnt_r == 16'hffff |=> cnt_r == 16'h0000 && overflow_irq)
		else $error("Free-running wrap wrong");
	a_ovf_cause: assert property (overflow_irq |-> $past(run) && $past(cnt_r) == 16'hffff)
		else $error("Overflow without counter at maximum");
	a_tp_preload: assert property (run && tp_en && !tp_arm_r |=> cnt_r == 16'h7fff)
		else $error("Two-phase preload missing");
	a_tp_underflow: assert property (qd_dn && !tp_load && cnt_r == 16'h0000 |=> cnt_r == 16'hffff)
		else $error("Underflow reload wrong");
	a_tp_overflow: assert property (qd_up && !tp_load && cnt_r == 16'hffff |=> cnt_r == 16'h0000)
		else $error("Two-phase overflow reload wrong");
	a_up_only: assert property (run && !tp_en && $past(run && !tp_en) && cnt_r != $past(cnt_r)
		|-> cnt_r == $past(cnt_r) + 16'h0001 || cnt_r == 16'h0000)
		else $error("Counter moved downward outside two-phase mode");
	// A period write moves the compare point one cycle before the flag follows it
	a_match_level: assert property (match_out == (count_out == period_r) or $changed(period_r))
		else $error("Match flag disagrees with counter");
	// Slower taps must coincide with every fourth and sixteenth fast tap, never elsewhere
	a_tap16_rate: assert property (tap_div16 == (tap_div1 && t1_cnt_r == 4'hf))
		else $error("Sixteen tap out of step with fast tap");
	a_tap4_rate: assert property (tap_div4 == (tap_div1 && t1_cnt_r[1:0] == 2'h3))
		else $error("Four tap out of step with fast tap");
	// Taps and external edges must not move a two-phase count
	a_tp_hold: assert property (s_tp_active ##0 (!qd_up && !qd_dn) |=> $stable(cnt_r))
		else $error("Two-phase count moved without a phase step");
	a_ext_edge: assert property (run && !tp_en && csel == tpu_pkg::CSEL_EXT && $rose(ext_s2_r) && cnt_r != 16'hffff
		&& !(mce && cnt_r == period_r) |=> cnt_r == $past(cnt_r) + 16'h0001)
		else $error("External edge not counted once");

endmodule

`default_nettype wire

// ==== shared/tpu_pkg.sv ====
// Constants for the prescaled 16-bit timer channel.
// Assumes one clock domain; the register port is word addressed with 16-bit data.
`default_nettype none

package tpu_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_MODE = 4'h1;
	localparam logic [3:0] OFF_PERIOD = 4'h2;
	localparam logic [3:0] OFF_COUNT = 4'h3;
	localparam logic [3:0] OFF_STATUS = 4'h4;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_PCLK_BIT = 1;
	localparam int CTRL_PSRC_LSB = 2;
	localparam int CTRL_GEAR_LSB = 4;
	localparam int CTRL_TPEN_BIT = 6;
	localparam int MODE_CSEL_LSB = 0;
	localparam int MODE_MCE_BIT = 2;
	localparam int STAT_MATCH_BIT = 0;
	localparam int STAT_RUN_BIT = 1;
	localparam int STAT_TPEN_BIT = 2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [15:0] PERIOD_RST = 16'hffff;

	// ----------------------------------------
	// Encodings and counter constants
	// ----------------------------------------
	localparam logic [1:0] PSRC_DIV16 = 2'h0;
	localparam logic [1:0] PSRC_DIV8 = 2'h1;
	localparam logic [1:0] PSRC_DIV4 = 2'h2;
	localparam logic [1:0] CSEL_EXT = 2'h0;
	localparam logic [1:0] CSEL_TAP1 = 2'h1;
	localparam logic [1:0] CSEL_TAP4 = 2'h2;
	localparam logic [1:0] CSEL_TAP16 = 2'h3;
	localparam logic [15:0] CNT_CLEAR = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] TP_PRELOAD = 16'h7fff;
	localparam logic [15:0] TP_OVF_LOAD = 16'h0000;
	localparam logic [15:0] TP_UDF_LOAD = 16'hffff;
endpackage

`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the prescaled 16-bit timer channel.
// Assumes the timer's register map and one-cycle read latency; the bench drives every port itself.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [15:0] ctrl; logic [15:0] mode; int gap;} tpu_row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic ext_clock_in = 1'b0;
	logic phase_b_in = 1'b0;
	logic overflow_irq;
	logic match_out;
	logic [15:0] count_out;
	logic [15:0] rd_v;
	logic [15:0] prev;
	int n_errors = 0;
	int n_compared = 0;
	int gap;
	int qi = 0;
	tpu_row_t rows [9];

	tpu_timer dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clock_in(ext_clock_in), .phase_b_in(phase_b_in),
		.overflow_irq(overflow_irq), .match_out(match_out), .count_out(count_out));

	// ----------------------------------------
	// Clock and shared tasks
	// ----------------------------------------
	// Ten nanosecond period
	always #5 clk = ~clk;

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_int(input int got, input int exp, input string what);
		n_compared++;
		if (got != exp) begin
			n_errors++;
			$display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
		end
	endtask

	// One-cycle strobes; a read's data stand only in the following cycle
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		rd_v = reg_rdata;
	endtask

	// Pin held high and low three cycles each, above the two-cycle minimum
	task automatic pulse(input bit on_b);
		@(posedge clk);
		if (on_b) phase_b_in <= 1'b1;
		else ext_clock_in <= 1'b1;
		repeat (3) @(posedge clk);
		phase_b_in <= 1'b0;
		ext_clock_in <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	// One quadrature step per cycle; A leading B counts up, B leading A counts down
	task automatic qstep(input bit up);
		@(posedge clk);
		qi = up ? (qi + 1) % 4 : (qi + 3) % 4;
		ext_clock_in <= (qi == 1 || qi == 2);
		phase_b_in <= (qi >= 2);
	endtask

	// Waits for the overflow pulse, checks the wrapped count and that the pulse lasts one cycle
	task automatic see_ovf(input logic [15:0] exp, input string what);
		int i;
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (overflow_irq !== 1'b1 && i < 50);
		chk16({15'h0000, overflow_irq}, 16'h0001, what);
		chk16(count_out, exp, what);
		@(negedge clk);
		chk16({15'h0000, overflow_irq}, 16'h0000, "overflow pulse length");
	endtask

	// Waits for one count step, then times the next one; the timed step must be plus one
	task automatic measure();
		int i;
		i = 0;
		prev = count_out;
		while (count_out === prev && i < 200) begin
			@(negedge clk);
			i++;
		end
		prev = count_out;
		gap = 0;
		while (count_out === prev && gap < 200) begin
			@(negedge clk);
			gap++;
		end
		chk16(count_out, prev + 16'h0001, "count step");
	endtask

	task automatic give_verdict();
		$display("Compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog: the two-phase run through zero takes about 33000 cycles, the rest under a thousand
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		$display("Error at %0t: watchdog expired", $time);
		give_verdict();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rows[0] = '{16'h000b, 16'h0001, 4};
		rows[1] = '{16'h0007, 16'h0001, 8};
		rows[2] = '{16'h0003, 16'h0001, 16};
		rows[3] = '{16'h000b, 16'h0002, 16};
		rows[4] = '{16'h000b, 16'h0003, 64};
		rows[5] = '{16'h0009, 16'h0001, 4};
		rows[6] = '{16'h0019, 16'h0001, 8};
		rows[7] = '{16'h0029, 16'h0001, 16};
		rows[8] = '{16'h0039, 16'h0001, 32};
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk16({overflow_irq, match_out, count_out[13:0]}, 16'h0000, "outputs after reset");
		rd(tpu_pkg::OFF_CTRL);
		chk16(rd_v, tpu_pkg::CTRL_RST, "ctrl reset");
		rd(tpu_pkg::OFF_MODE);
		chk16(rd_v, tpu_pkg::MODE_RST, "mode reset");
		wr(4'h7, 16'h1234);
		rd(tpu_pkg::OFF_PERIOD);
		chk16(rd_v, tpu_pkg::PERIOD_RST, "period after unmapped write");
		rd(4'h5);
		chk16(rd_v, 16'h0000, "unmapped read");
		$display("Test reset and map done");
		for (int r = 0; r < 9; r++) begin
			wr(tpu_pkg::OFF_CTRL, 16'h0000);
			wr(tpu_pkg::OFF_MODE, rows[r].mode);
			wr(tpu_pkg::OFF_CTRL, rows[r].ctrl);
			measure();
			chk_int(gap, rows[r].gap, "tick spacing");
		end
		$display("Test clock rates done");
		wr(tpu_pkg::OFF_CTRL, 16'h0000);
		wr(tpu_pkg::OFF_PERIOD, 16'h0002);
		wr(tpu_pkg::OFF_MODE, 16'h0005);
		wr(tpu_pkg::OFF_CTRL, 16'h000b);
		prev = 16'h0000;
		repeat (60) begin
			@(negedge clk);
			chk16({15'h0000, count_out > 16'h0002 || overflow_irq}, 16'h0000, "clear at period");
			if (count_out === prev)
				chk16({15'h0000, match_out}, {15'h0000, count_out == 16'h0002}, "match");
			prev = count_out;
		end
		wr(tpu_pkg::OFF_MODE, 16'h0001);
		for (int i = 0; i < 40 && count_out !== 16'h0005; i++) @(negedge clk);
		chk16(count_out, 16'h0005, "passes period when clear off");
		wr(tpu_pkg::OFF_CTRL, 16'h0000);
		repeat (20) @(negedge clk);
		chk16(count_out, tpu_pkg::CNT_CLEAR, "stopped and cleared");
		$display("Test match and stop done");
		wr(tpu_pkg::OFF_MODE, 16'h0000);
		wr(tpu_pkg::OFF_CTRL, 16'h0001);
		repeat (5) pulse(1'b0);
		repeat (2) pulse(1'b1);
		repeat (4) @(negedge clk);
		chk16(count_out, 16'h0005, "external pulses");
		wr(tpu_pkg::OFF_CTRL, 16'h0000);
		wr(tpu_pkg::OFF_CTRL, 16'h0041);
		repeat (4) @(negedge clk);
		chk16(count_out, tpu_pkg::TP_PRELOAD, "two-phase preload");
		rd(tpu_pkg::OFF_STATUS);
		chk16(rd_v, 16'h0006, "status");
		qstep(1'b1);
		repeat (4) @(negedge clk);
		chk16(count_out, 16'h8000, "phase up");
		repeat (32769) qstep(1'b0);
		repeat (4) @(negedge clk);
		chk16(count_out, tpu_pkg::TP_UDF_LOAD, "phase down through zero");
		qstep(1'b1);
		see_ovf(tpu_pkg::TP_OVF_LOAD, "two-phase overflow");
		qstep(1'b0);
		repeat (4) @(negedge clk);
		chk16(count_out, tpu_pkg::TP_UDF_LOAD, "underflow again");
		$display("Test external and two-phase done");
		wr(tpu_pkg::OFF_MODE, 16'h0001);
		wr(tpu_pkg::OFF_CTRL, 16'h000b);
		see_ovf(tpu_pkg::CNT_CLEAR, "free-running wrap");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk16(count_out, tpu_pkg::CNT_CLEAR, "count after mid-run reset");
		chk16({14'h0000, overflow_irq, match_out}, 16'h0000, "flags after mid-run reset");
		rd(tpu_pkg::OFF_CTRL);
		chk16(rd_v, tpu_pkg::CTRL_RST, "ctrl after mid-run reset");
		$display("Test wrap and mid-run reset done");
		give_verdict();
	end
endmodule

`default_nettype wire
